// *** pkg/ea_decoder_map.vh ***
`ifndef EA_DECODER_MAP_VH
`define EA_DECODER_MAP_VH
// ---------------------------------------------------------------
// register map (byte offsets)
// ---------------------------------------------------------------
`define REG_CTRL      5'h00
`define REG_INSTR     5'h04
`define REG_STATUS    5'h08
`define REG_EA        5'h0c
`define REG_DEV       5'h10
`define REG_PC        5'h14
`define REG_FLAGS     5'h18
// ---------------------------------------------------------------
// field positions (bit 35 is msb of the 36-bit word)
// ---------------------------------------------------------------
`define F_OP_HI       35
`define F_OP_LO       27
`define F_AC_HI       26
`define F_AC_LO       23
`define F_DEV_HI      32
`define F_DEV_LO      26
`define F_IOP_HI      25
`define F_IOP_LO      23
`define F_IND         22
`define F_X_HI        21
`define F_X_LO        18
`define F_Y_HI        17
`define F_Y_LO        0
// ---------------------------------------------------------------
// fixed locations and reset values
// ---------------------------------------------------------------
`define LOC_UUO_SAVE  18'o000040
`define LOC_UUO_EXEC  18'o000041
`define PC_RESET      18'h00000
`define FLAGS_RESET   13'h0000
`endif

// *** src/effective_address_decoder.v ***
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "ea_decoder_map.vh"
module effective_address_decoder #(
  parameter NUM_UNUSED = 26,
  parameter [511:0] UNUSED_MAP = 512'h0
) (
  input  wire        sys_clk,
  input  wire        rstn,
  input  wire        clk_en,
  // axi4-lite slave
  input  wire [4:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [4:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // memory port
  output reg         mem_req,
  output reg         mem_we,
  output reg  [17:0] mem_addr,
  output reg  [35:0] mem_wdata,
  input  wire        mem_ack,
  input  wire [35:0] mem_rdata,
  // decoded results
  output reg  [8:0]  op_code,
  output reg  [3:0]  ac_sel,
  output reg  [3:0]  ac_pair_sel,
  output reg  [6:0]  io_dev,
  output reg  [2:0]  io_op,
  output reg  [17:0] eff_addr,
  output reg  [35:0] operand,
  output reg         done,
  output reg         is_nop,
  output reg         is_uuo
);

  // ---------------------------------------------------------------
  // state encoding
  // ---------------------------------------------------------------
  localparam S_IDLE  = 3'd0;
  localparam S_XRD   = 3'd1;
  localparam S_IND   = 3'd2;
  localparam S_OPRD  = 3'd3;
  localparam S_SAVE  = 3'd4;
  localparam S_TRAP  = 3'd5;
  localparam S_DONE  = 3'd6;

  reg [2:0]  state_q;
  reg [35:0] instr_q;
  reg [35:0] word_q;
  reg [17:0] ea_q;
  reg [17:0] pc_q;
  reg [12:0] processor_condition_flags_q;
  reg        imm_q;
  reg        start_q;
  reg        busy_q;

  // ---------------------------------------------------------------
  // axi write path
  // ---------------------------------------------------------------
  reg        aw_hold_q;
  reg        w_hold_q;
  reg [4:0]  awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0]  wstrb_q;
  wire       wr_fire;

  assign s_axi_awready = ~aw_hold_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold_q & ~s_axi_bvalid;
  assign wr_fire = (aw_hold_q | s_axi_awvalid) & (w_hold_q | s_axi_wvalid)
                   & ~s_axi_bvalid;

  wire [4:0]  wa = aw_hold_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wd = w_hold_q ? wdata_q : s_axi_wdata;
  wire [3:0]  ws = w_hold_q ? wstrb_q : s_axi_wstrb;

  // address and data may land in either order
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      aw_hold_q    <= 1'b0;
      w_hold_q     <= 1'b0;
      awaddr_q     <= 5'h00;
      wdata_q      <= 32'h0;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else if (clk_en) begin
      if (wr_fire) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wa == `REG_CTRL || wa == `REG_INSTR ||
                         wa == `REG_PC || wa == `REG_FLAGS) ? 2'b00 : 2'b10;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_hold_q <= 1'b1;
          awaddr_q  <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_hold_q <= 1'b1;
          wdata_q  <= s_axi_wdata;
          wstrb_q  <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready)
          s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // software-visible control: instruction, pc, flags, start
  // ---------------------------------------------------------------
  reg [35:0] instr_sw_q;
  wire [35:0] mask_wd = {{4{ws[0]}}, {8{ws[3]}}, {8{ws[2]}},
                         {8{ws[1]}}, {8{ws[0]}}};
  wire        ctrl_go = wr_fire && wa == `REG_CTRL && ws[0] && wd[0];

  // instruction word, start, imm and condition flags live here; pc lives in the engine
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      instr_sw_q <= 36'h0;
      start_q    <= 1'b0;
      imm_q      <= 1'b0;
      processor_condition_flags_q <= `FLAGS_RESET;
    end else if (clk_en) begin
      start_q <= ctrl_go & ~busy_q;
      if (ctrl_go && ws[0])
        imm_q <= wd[1];
      if (wr_fire && wa == `REG_INSTR)
        instr_sw_q[31:0] <= (instr_sw_q[31:0] & ~mask_wd[31:0]) |
                            (wd & mask_wd[31:0]);
      if (wr_fire && wa == `REG_CTRL && ws[1])
        instr_sw_q[35:32] <= wd[11:8];
      if (wr_fire && wa == `REG_FLAGS && ws[0])
        processor_condition_flags_q[7:0] <= wd[7:0];
      if (wr_fire && wa == `REG_FLAGS && ws[1])
        processor_condition_flags_q[12:8] <= wd[12:8];
    end
  end

  // ---------------------------------------------------------------
  // address calculation engine
  // ---------------------------------------------------------------
  wire [3:0]  x_fld   = word_q[`F_X_HI:`F_X_LO];
  wire [17:0] y_fld   = word_q[`F_Y_HI:`F_Y_LO];
  wire [8:0]  op_w    = instr_q[`F_OP_HI:`F_OP_LO];
  wire        uuo_w   = (op_w[8:6] == 3'b000);
  wire        unused_w = UNUSED_MAP[op_w];

  // all memory reads share one request shape
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q   <= S_IDLE;
      busy_q    <= 1'b0;
      instr_q   <= 36'h0;
      word_q    <= 36'h0;
      ea_q      <= 18'h0;
      pc_q      <= `PC_RESET;
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= 18'h0;
      mem_wdata <= 36'h0;
      operand   <= 36'h0;
      eff_addr  <= 18'h0;
      done      <= 1'b0;
      is_nop    <= 1'b0;
      is_uuo    <= 1'b0;
      op_code   <= 9'h0;
      ac_sel    <= 4'h0;
      ac_pair_sel <= 4'h0;
      io_dev    <= 7'h0;
      io_op     <= 3'h0;
    end else if (clk_en) begin
      done <= 1'b0;
      if (wr_fire && wa == `REG_PC && !busy_q)
        pc_q <= wd[17:0];
      case (state_q)
        S_IDLE: if (start_q) begin
          busy_q  <= 1'b1;
          instr_q <= instr_sw_q;
          word_q  <= instr_sw_q;
          ea_q    <= instr_sw_q[`F_Y_HI:`F_Y_LO];
          state_q <= (instr_sw_q[`F_X_HI:`F_X_LO] != 4'h0) ? S_XRD : S_IND;
          if (instr_sw_q[`F_X_HI:`F_X_LO] != 4'h0) begin
            // index register is a low memory word
            mem_req  <= 1'b1;
            mem_we   <= 1'b0;
            mem_addr <= {14'h0, instr_sw_q[`F_X_HI:`F_X_LO]};
          end
        end
        S_XRD: if (mem_ack) begin
          mem_req <= 1'b0;
          // right half only, carry out dropped
          ea_q    <= y_fld + mem_rdata[17:0];
          state_q <= S_IND;
        end
        S_IND: if (word_q[`F_IND]) begin
          // no depth limit; reset is the only escape
          mem_req  <= 1'b1;
          mem_we   <= 1'b0;
          mem_addr <= ea_q;
          state_q  <= S_OPRD;
        end else begin
          eff_addr <= ea_q;
          if (uuo_w) begin
            mem_req   <= 1'b1;
            mem_we    <= 1'b1;
            mem_addr  <= `LOC_UUO_SAVE;
            mem_wdata <= {instr_q[35:18], ea_q};
            state_q   <= S_SAVE;
          end else begin
            operand <= {18'h0, ea_q};
            state_q <= S_DONE;
          end
        end
        S_OPRD: if (mem_ack) begin
          mem_req <= 1'b0;
          word_q  <= mem_rdata;
          ea_q    <= mem_rdata[`F_Y_HI:`F_Y_LO];
          if (mem_rdata[`F_X_HI:`F_X_LO] != 4'h0) begin
            mem_req  <= 1'b1;
            mem_addr <= {14'h0, mem_rdata[`F_X_HI:`F_X_LO]};
            state_q  <= S_XRD;
          end else
            state_q <= S_IND;
        end
        S_SAVE: if (mem_ack) begin
          mem_we   <= 1'b0;
          mem_addr <= `LOC_UUO_EXEC;
          state_q  <= S_TRAP;
        end
        S_TRAP: if (mem_ack) begin
          mem_req <= 1'b0;
          instr_q <= mem_rdata;
          operand <= mem_rdata;
          state_q <= S_DONE;
        end
        S_DONE: begin
          op_code     <= instr_q[`F_OP_HI:`F_OP_LO];
          ac_sel      <= instr_q[`F_AC_HI:`F_AC_LO];
          ac_pair_sel <= instr_q[`F_AC_HI:`F_AC_LO] + 4'h1;
          io_dev      <= instr_q[`F_DEV_HI:`F_DEV_LO];
          io_op       <= instr_q[`F_IOP_HI:`F_IOP_LO];
          is_uuo      <= uuo_w;
          is_nop      <= unused_w & ~uuo_w;
          // pc advances in sequence unless instr_q holds a uuo, which after a trap is the word read from 041
          if (!uuo_w)
            pc_q <= pc_q + 18'h1;
          done    <= 1'b1;
          busy_q  <= 1'b0;
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // axi read path, one cycle latency
  // ---------------------------------------------------------------
  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= 2'b00;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        if (s_axi_araddr == `REG_CTRL)
          s_axi_rdata <= {20'h0, instr_sw_q[35:32], 6'h0, imm_q, 1'b0};
        else if (s_axi_araddr == `REG_INSTR)
          s_axi_rdata <= instr_sw_q[31:0];
        else if (s_axi_araddr == `REG_STATUS)
          s_axi_rdata <= {28'h0, is_uuo, is_nop, state_q == S_IDLE, busy_q};
        else if (s_axi_araddr == `REG_EA)
          s_axi_rdata <= {14'h0, eff_addr};
        else if (s_axi_araddr == `REG_DEV)
          s_axi_rdata <= {9'h0, op_code, ac_sel, io_dev, io_op};
        else if (s_axi_araddr == `REG_PC)
          s_axi_rdata <= {14'h0, pc_q};
        else if (s_axi_araddr == `REG_FLAGS)
          s_axi_rdata <= {19'h0, processor_condition_flags_q};
        else begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'b10;  // unmapped: slverr
        end
      end else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule // effective_address_decoder

// *** tb/ea_props_properties.sv ***
`timescale 1ns/1ps
// -------------------------------
// port properties of the decoder
// -------------------------------
module ea_props (
  input logic        sys_clk,
  input logic        rstn,
  input logic        mem_req,
  input logic        mem_we,
  input logic        mem_ack,
  input logic        done,
  input logic        is_nop,
  input logic        is_uuo,
  input logic [17:0] mem_addr,
  input logic [17:0] eff_addr,
  input logic [8:0]  op_code,
  input logic [3:0]  ac_sel,
  input logic [3:0]  ac_pair_sel,
  input logic [35:0] operand
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // trap save answered, then the trap word is fetched
  sequence save_w;
    mem_req && mem_ack && mem_we;
  endsequence
  sequence trap_rd;
    mem_req && !mem_we && mem_addr == 18'o41;
  endsequence
  a_req_hold: assert property (mem_req && !mem_ack |=>
    mem_req && $stable(mem_addr) && $stable(mem_we)) else $error("req moved");
  a_trap_fetch: assert property (save_w |-> ##[1:4] trap_rd)
    else $error("no trap fetch");
  a_save_addr: assert property (mem_req && mem_we |-> mem_addr == 18'o40)
    else $error("write not at save word");
  a_pair_wrap: assert property (done |-> ac_pair_sel == ac_sel + 4'h1)
    else $error("bad pair");
  a_trap_code: assert property (done |-> is_uuo == (op_code[8:6] == 3'h0))
    else $error("trap flag wrong");
  a_imm_oper: assert property (done && !is_uuo |->
    operand == {18'h0, eff_addr}) else $error("operand not address");
  a_done_idle: assert property (done |-> !mem_req)
    else $error("done with access open");
  a_nop_quiet: assert property (done && is_nop |-> !is_uuo)
    else $error("nop trapped");
endmodule // ea_props
bind effective_address_decoder ea_props ea_props_inst (.sys_clk, .rstn,
  .mem_req, .mem_we, .mem_ack, .done, .is_nop, .is_uuo, .mem_addr,
  .eff_addr, .op_code, .ac_sel, .ac_pair_sel, .operand);

// *** tb/effective_address_decoder_tb.sv ***
`timescale 1ns/1ps
`include "ea_decoder_map.vh"
// -------------------------------
// decoder bench
// -------------------------------
module effective_address_decoder_tb;
  localparam [511:0] NOPS = 512'h3ffffff << 256;
  logic sys_clk = 1'b0, rstn = 1'b0, clk_en = 1'b1;
  logic [4:0] s_axi_awaddr = 5'h0, s_axi_araddr = 5'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf, ac_sel, ac_pair_sel, lat = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready;
  logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic mem_req, mem_we, mem_ack, done, is_nop, is_uuo;
  logic [17:0] mem_addr, eff_addr;
  logic [35:0] mem_wdata, mem_rdata, operand, w;
  logic [31:0] pc0, pc1, d;
  logic [8:0] op_code;
  logic [6:0] io_dev;
  logic [2:0] io_op;
  int fails = 0, checks = 0, n0;
  effective_address_decoder #(.UNUSED_MAP(NOPS))
    effective_address_decoder_inst (.*);
  word_memory word_memory_inst (.*);
  // 20 MHz clock
  initial forever #25 sys_clk = ~sys_clk;
  task automatic chk(input string n, input logic [35:0] s, e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  // write: both channels offered, each released when taken
  task automatic wr(input logic [4:0] a, input logic [31:0] v,
                    input logic [1:0] er);
    logic aw_ok, w_ok;
    @(posedge sys_clk);
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge sys_clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      aw_ok |= s_axi_awready;
      w_ok |= s_axi_wready;
    end
    do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, er);
  endtask
  task automatic rd(input logic [4:0] a, input logic [1:0] er);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk("rresp", s_axi_rresp, er);
  endtask
  // load one word, start, wait bounded for done; pc around it
  task automatic run(input logic imm);
    int n;
    rd(`REG_PC, 2'h0);
    pc0 = d;
    wr(`REG_INSTR, w[31:0], 2'h0);
    wr(`REG_CTRL, {20'h0, w[35:32], 6'h0, imm, 1'b1}, 2'h0);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (done !== 1'b1 && n < 500);
    chk("done", done, 1'b1);
    rd(`REG_PC, 2'h0);
    pc1 = d;
  endtask
  task automatic t_regs;
    rd(`REG_PC, 2'h0);
    chk("pc_reset", d, 32'h0);
    rd(`REG_FLAGS, 2'h0);
    chk("flags_reset", d, 32'h0);
    rd(5'h1c, 2'h2);
    chk("unmapped", d, 32'h0);
    wr(5'h1c, 32'h1, 2'h2);
  endtask
  // two indirect hops, left halves and word 0 must not count
  task automatic t_chain;
    w = {9'o200, 4'hf, 1'b1, 4'h3, 18'h00010};
    word_memory_inst.mem[0] = {18'h0, 18'h00100};
    word_memory_inst.mem[3] = {18'h3ffff, 18'h00020};
    word_memory_inst.mem[2] = {18'h1, 18'h00044};
    word_memory_inst.mem[8'h30] = {13'h0, 1'b1, 4'h0, 18'h00040};
    word_memory_inst.mem[8'h40] = {13'h0, 1'b0, 4'h2, 18'h00011};
    run(1'b1);
    chk("ea", eff_addr, 18'h00055);
    chk("imm_operand", operand, 36'h55);
    chk("op", op_code, 9'o200);
    chk("ac", ac_sel, 4'hf);
    chk("pair", ac_pair_sel, 4'h0);
    chk("pc_step", pc1, pc0 + 32'h1);
    rd(`REG_EA, 2'h0);
    chk("ea_reg", d, 32'h00055);
    rd(`REG_STATUS, 2'h0);
    chk("status_idle", d, 32'h2);
  endtask
  // slow memory, i/o fields, index carry dropped
  task automatic t_io;
    w = {3'b111, 7'h45, 3'h5, 1'b0, 4'h5, 18'h00002};
    word_memory_inst.mem[5] = {18'h2aaaa, 18'h3ffff};
    lat = 4'h3;
    run(1'b0);
    chk("dev", io_dev, 7'h45);
    chk("iop", io_op, 3'h5);
    chk("ea_wrap", eff_addr, 18'h00001);
    rd(`REG_DEV, 2'h0);
    chk("dev_reg", d, {9'h0, 9'h1e2, 4'hd, 7'h45, 3'h5});
  endtask
  task automatic t_uuo;
    w = {9'o017, 4'h2, 1'b0, 4'h0, 18'h00077};
    word_memory_inst.mem[8'h21] = 36'h123456789;
    lat = 4'h1;
    run(1'b0);
    chk("save", word_memory_inst.mem[8'h20], {w[35:18], 18'h77});
    chk("uuo", is_uuo, 1'b1);
    chk("trap_op", operand, 36'h123456789);
    chk("trap_pc", pc1, pc0);
  endtask
  task automatic t_nop;
    w = {9'o400, 4'h1, 1'b0, 4'h0, 18'h00003};
    n0 = word_memory_inst.writes;
    run(1'b0);
    chk("nop", is_nop, 1'b1);
    chk("nop_uuo", is_uuo, 1'b0);
    chk("nop_writes", word_memory_inst.writes, n0);
    rd(`REG_STATUS, 2'h0);
    chk("status_nop", d, 32'h6);
  endtask
  task automatic complete_run;
    if (fails == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // main sequence after 6 reset cycles
  initial begin
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    t_regs;
    t_chain;
    t_io;
    t_uuo;
    t_nop;
    complete_run;
  end
  // watchdog well past the expected run
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    complete_run;
  end
endmodule // effective_address_decoder_tb

// *** tb/word_memory.sv ***
`timescale 1ns/1ps
// -------------------------------
// word memory, settable latency
// -------------------------------
module word_memory (
  input  logic        sys_clk,
  input  logic        rstn,
  input  logic        mem_req,
  input  logic        mem_we,
  input  logic [17:0] mem_addr,
  input  logic [35:0] mem_wdata,
  input  logic [3:0]  lat,
  output logic        mem_ack,
  output logic [35:0] mem_rdata
);
  logic [35:0] mem [0:255];
  int          cnt;
  int          writes;
  // only 256 words: higher addresses alias; idle data scrambles
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mem_ack <= 1'b0;
      mem_rdata <= 36'h0;
      cnt <= 0;
      writes <= 0;
    end else if (mem_req && !mem_ack && cnt < lat) begin
      cnt <= cnt + 1;
    end else if (mem_req && !mem_ack) begin
      cnt <= 0;
      mem_ack <= 1'b1;
      if (mem_we)
        mem[mem_addr[7:0]] <= mem_wdata;
      else
        mem_rdata <= mem[mem_addr[7:0]];
      writes <= writes + mem_we;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // word_memory
